/* File: hdl/ovtr_heat.sv */
// Highest phase current, overload compare and heating limit arithmetic.
`timescale 1ns/1ps
module ovtr_heat
	import ovtr_pkg::*;
(
	// Measurements and parameters.
	input  wire ovtr_pkg::ovtr_phases_t    phases,
	input  wire logic [ovtr_pkg::AMP_W-1:0] setpoint,
	input  wire logic [7:0]                 sdelay,
	// Results.
	output logic [ovtr_pkg::AMP_W-1:0]      highest,
	output logic                            over,
	output logic [2*ovtr_pkg::AMP_W-1:0]    isq,
	output logic [ovtr_pkg::ACC_W-1:0]      limit
);
	import ovtr_pkg::*;

	// Larger of two currents.
	function automatic logic [AMP_W-1:0] max2(input logic [AMP_W-1:0] x,
		input logic [AMP_W-1:0] y);
		max2 = (x > y) ? x : y;
	endfunction : max2

	logic [2*AMP_W-1:0] sp_sq; // Setpoint squared.

	// The largest phase is the one judged, never a fixed phase.
	always_comb begin
		highest = max2(max2(phases.a, phases.b), phases.c); // RQ1
		over    = highest > setpoint; // RQ3
		isq     = highest * highest;
		sp_sq   = setpoint * setpoint;
		// Limit equals 2.25 * SP^2 * delay in tenths, doubled to stay integer.
		limit   = ACC_W'(HEAT_FACTOR) * ACC_W'(sp_sq) * ACC_W'(sdelay); // RQ8 RQ9
	end

endmodule : ovtr_heat

/* File: hdl/ovtr_pkg.sv */
// Constants, register map and carrier types of the overload trip and restart block.
package ovtr_pkg;

	// Clock period and the tenth-of-a-second time base.
	localparam int unsigned CLK_PERIOD_NS  = 50;
	localparam int unsigned TENTH_NS       = 100_000_000;
	localparam int unsigned TENTH_CYCLES   = TENTH_NS / CLK_PERIOD_NS;
	localparam int unsigned TENTHS_PER_SEC = 10;

	// Heat limit factor: trip when 2 * sum(I*I per tenth) >= 45 * SP*SP * delay.
	// That is 1.5 squared, times ten tenths per second, times two.
	localparam int unsigned HEAT_FACTOR = 45;

	// Widths.
	localparam int unsigned AMP_W  = 16;
	localparam int unsigned ACC_W  = 48;
	localparam int unsigned TICK_W = 21;
	localparam int unsigned WCNT_W = 20;
	localparam int unsigned EV_W   = 4;

	// Register byte offsets.
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_CMD      = 8'h04;
	localparam logic [7:0] ADDR_SETPOINT = 8'h08;
	localparam logic [7:0] ADDR_BYPASS   = 8'h0c;
	localparam logic [7:0] ADDR_SDELAY   = 8'h10;
	localparam logic [7:0] ADDR_LSTARTS  = 8'h14;
	localparam logic [7:0] ADDR_LDELAY   = 8'h18;
	localparam logic [7:0] ADDR_GSTARTS  = 8'h1c;
	localparam logic [7:0] ADDR_GDELAY   = 8'h20;
	localparam logic [7:0] ADDR_HIGHEST  = 8'h24;
	localparam logic [7:0] ADDR_STATUS   = 8'h28;
	localparam logic [7:0] ADDR_INT_STAT = 8'h2c;
	localparam logic [7:0] ADDR_INT_MASK = 8'h30;

	// Field positions of the control, command and event registers.
	localparam int unsigned CTRL_LOCKOUT = 0;
	localparam int unsigned CTRL_RSTRT   = 1;
	localparam int unsigned CTRL_AUX     = 2;
	localparam int unsigned CMD_START    = 0;
	localparam int unsigned CMD_STOP     = 1;
	localparam int unsigned CMD_CLEAR    = 2;
	localparam int unsigned EV_TRIP      = 0;
	localparam int unsigned EV_INSTANT   = 1;
	localparam int unsigned EV_LOCK      = 2;
	localparam int unsigned EV_RESTART   = 3;

	// Values after reset of the operator parameters.
	localparam logic [15:0] SETPOINT_RST = 16'h0032;
	localparam logic [15:0] BYPASS_RST   = 16'h0003;
	localparam logic [7:0]  SDELAY_RST   = 8'h08;
	localparam logic [7:0]  LSTARTS_RST  = 8'h01;
	localparam logic [15:0] LDELAY_RST   = 16'h0708;
	localparam logic [7:0]  GSTARTS_RST  = 8'h03;
	localparam logic [15:0] GDELAY_RST   = 16'h0708;

	// Operating modes of the protection sequence.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_BYPASS,
		ST_RUN,
		ST_WAIT,
		ST_LOCK
	} ovtr_mode_t;

	// The three measured phase currents.
	typedef struct packed {
		logic [AMP_W-1:0] a;
		logic [AMP_W-1:0] b;
		logic [AMP_W-1:0] c;
	} ovtr_phases_t;

	// Operator parameters held in registers.
	typedef struct packed {
		logic             lockout_en;
		logic             rstrt_on_ovld;
		logic             aux_sel;
		logic [AMP_W-1:0] setpoint;
		logic [15:0]      bypass;
		logic [7:0]       sdelay;
		logic [7:0]       lstarts;
		logic [15:0]      ldelay;
		logic [7:0]       gstarts;
		logic [15:0]      gdelay;
	} ovtr_cfg_t;

	// Complete state of the top module.
	typedef struct packed {
		ovtr_cfg_t         cfg;
		ovtr_mode_t        mode;
		logic [AMP_W-1:0]  highest;
		logic [TICK_W-1:0] tick;
		logic [15:0]       bcnt;
		logic [ACC_W-1:0]  acc;
		logic [WCNT_W-1:0] wcnt;
		logic [7:0]        left;
		logic [EV_W-1:0]   ev;
		logic [EV_W-1:0]   mask;
		logic [31:0]       prdata;
		logic              run;
		logic              restart;
	} ovtr_state_t;

endpackage : ovtr_pkg

/* File: hdl/ovtr_top.sv */
// Overload trip, lockout and automatic restart controller with APB registers.
// Operation
// RQ1 - Judge overload on largest phase current.
// RQ2 - Highest current readable, never writable.
// RQ3 - Only current above setpoint starts tripping.
// RQ4 - Overload protection cannot be disabled.
// RQ5 - Lockout enable blocks restarts after trip.
// RQ6 - Ignore overload during bypass, tenths units.
// RQ7 - Shutdown timing starts after bypass expiry.
// RQ8 - Delay is trip time at 150%.
// RQ9 - Trip time scales inverse square.
// RQ10 - Heavy drive load trips instantly.
// RQ11 - Restart option selects local set, one start.
// RQ12 - Local set or global restart parameters.
// RQ13 - Limit restarts to allowed-starts count.
// RQ14 - Wait restart delay before restarting.
// RQ15 - Clear heat sum when current drops.
// RQ16 - Operator clear ends lockout, re-arms counter.
`timescale 1ns/1ps
module ovtr_top
	import ovtr_pkg::*;
#(
	parameter int unsigned TENTH_CYCLES_P = ovtr_pkg::TENTH_CYCLES
)(
	// Clock and reset.
	input  wire logic                   ref_clk,
	input  wire logic                   rst,
	// APB slave.
	input  wire logic                   psel,
	input  wire logic                   penable,
	input  wire logic                   pwrite,
	input  wire logic [7:0]             paddr,
	input  wire logic [31:0]            pwdata,
	output logic [31:0]                 prdata,
	output logic                        pready,
	output logic                        pslverr,
	// Measurement and power stage.
	input  wire ovtr_pkg::ovtr_phases_t phases,
	input  wire logic                   instant_trip,
	output logic                        motor_run,
	output logic                        restart_pulse,
	// Interrupt.
	output logic                        irq
);
	import ovtr_pkg::*;

	ovtr_state_t        q;         // Registered state.
	ovtr_state_t        d;         // Next state.
	logic [AMP_W-1:0]   highest_w; // Largest phase now.
	logic               over_w;    // Largest phase above setpoint.
	logic [2*AMP_W-1:0] isq_w;     // Largest phase squared.
	logic [ACC_W-1:0]   limit_w;   // Doubled heating limit.

	// Overload arithmetic on the live measurements.
	ovtr_heat u_heat (
		.phases   (phases),
		.setpoint (q.cfg.setpoint),
		.sdelay   (q.cfg.sdelay),
		.highest  (highest_w),
		.over     (over_w),
		.isq      (isq_w),
		.limit    (limit_w)
	);

	// True for an offset that maps a register.
	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a[1:0] == 2'b00) && (a <= ADDR_INT_MASK);
	endfunction : addr_ok

	// Read value of the register at offset a.
	function automatic logic [31:0] reg_read(input ovtr_state_t s,
		input logic [7:0] a);
		reg_read = 32'h0000_0000;
		case (a)
			ADDR_CTRL:     reg_read = {29'h0, s.cfg.aux_sel,
				s.cfg.rstrt_on_ovld, s.cfg.lockout_en};
			ADDR_SETPOINT: reg_read = {16'h0, s.cfg.setpoint};
			ADDR_BYPASS:   reg_read = {16'h0, s.cfg.bypass};
			ADDR_SDELAY:   reg_read = {24'h0, s.cfg.sdelay};
			ADDR_LSTARTS:  reg_read = {24'h0, s.cfg.lstarts};
			ADDR_LDELAY:   reg_read = {16'h0, s.cfg.ldelay};
			ADDR_GSTARTS:  reg_read = {24'h0, s.cfg.gstarts};
			ADDR_GDELAY:   reg_read = {16'h0, s.cfg.gdelay};
			ADDR_HIGHEST:  reg_read = {16'h0, s.highest}; // RQ2
			// Alarm enable always reads one: protection is fixed on.
			ADDR_STATUS:   reg_read = {15'h0, 1'b1, s.left, 4'h0,
				s.run, 3'(s.mode)}; // RQ4
			ADDR_INT_STAT: reg_read = {28'h0, s.ev};
			ADDR_INT_MASK: reg_read = {28'h0, s.mask};
			default:       reg_read = 32'h0000_0000;
		endcase
	endfunction : reg_read

	logic               wr;          // APB write in access phase.
	logic               tenth;       // Time base tick.
	logic               start_cmd;   // Operator start.
	logic               stop_cmd;    // Operator stop.
	logic               clear_cmd;   // Operator lockout clear.
	logic               do_trip;     // Overload shutdown this cycle.
	logic               inst_trip;   // The shutdown is instantaneous.
	logic               use_local;   // Local retry parameters in force.
	logic [7:0]         allowed;     // Restart count in force.
	logic [15:0]        delay_s;     // Restart delay in seconds.
	logic [ACC_W-1:0]   heat_sum;    // Heat sum after this tenth.
	logic               heat_full;   // Heat sum reached the limit.
	logic [EV_W-1:0]    ev_set;      // Events raised this cycle.
	logic [EV_W-1:0]    ev_clr;      // Event bits written with one.

	// Next-state logic of the whole block.
	always_comb begin
		d         = q;
		d.restart = 1'b0;
		ev_set    = '0;
		ev_clr    = '0;
		do_trip   = 1'b0;
		inst_trip = 1'b0;
		wr        = psel && penable && pwrite && addr_ok(paddr);
		start_cmd = wr && (paddr == ADDR_CMD) && pwdata[CMD_START];
		stop_cmd  = wr && (paddr == ADDR_CMD) && pwdata[CMD_STOP];
		clear_cmd = wr && (paddr == ADDR_CMD) && pwdata[CMD_CLEAR];
		// Tenth-of-a-second time base.
		tenth  = q.tick == TICK_W'(TENTH_CYCLES_P - 1);
		d.tick = tenth ? '0 : q.tick + TICK_W'(1);
		d.highest = highest_w; // RQ2
		// Restart option forces the local set and a single start.
		use_local = q.cfg.rstrt_on_ovld || q.cfg.aux_sel; // RQ11 RQ12
		allowed   = q.cfg.rstrt_on_ovld ? 8'h01 :
			(q.cfg.aux_sel ? q.cfg.lstarts : q.cfg.gstarts); // RQ11 RQ13
		delay_s   = use_local ? q.cfg.ldelay : q.cfg.gdelay; // RQ12
		heat_sum  = q.acc + ACC_W'(isq_w);
		heat_full = {heat_sum, 1'b0} >= {1'b0, limit_w}; // RQ8 RQ9
		// Read data is captured in the setup phase.
		if (psel && !penable) begin
			d.prdata = reg_read(q, paddr);
		end
		// Parameter writes; highest and status are not writable.
		if (wr) begin
			case (paddr)
				ADDR_CTRL: begin
					d.cfg.lockout_en    = pwdata[CTRL_LOCKOUT];
					d.cfg.rstrt_on_ovld = pwdata[CTRL_RSTRT];
					d.cfg.aux_sel       = pwdata[CTRL_AUX];
				end
				ADDR_SETPOINT: d.cfg.setpoint = pwdata[15:0];
				ADDR_BYPASS:   d.cfg.bypass   = pwdata[15:0];
				ADDR_SDELAY:   d.cfg.sdelay   = pwdata[7:0];
				ADDR_LSTARTS:  d.cfg.lstarts  = pwdata[7:0];
				ADDR_LDELAY:   d.cfg.ldelay   = pwdata[15:0];
				ADDR_GSTARTS:  d.cfg.gstarts  = pwdata[7:0];
				ADDR_GDELAY:   d.cfg.gdelay   = pwdata[15:0];
				ADDR_INT_STAT: ev_clr         = pwdata[EV_W-1:0];
				ADDR_INT_MASK: d.mask         = pwdata[EV_W-1:0];
				default: begin
					// Other offsets ignore writes.
				end
			endcase
		end
		// Protection sequence.
		case (q.mode)
			ST_IDLE: begin
				// A manual start arms the restart counter.
				if (start_cmd) begin
					d.mode = ST_BYPASS;
					d.bcnt = q.cfg.bypass;
					d.left = allowed;
					d.run  = 1'b1;
				end
			end
			ST_BYPASS: begin
				// Overload is ignored here; only the drive self-trip acts.
				if (instant_trip) begin
					do_trip   = 1'b1; // RQ10
					inst_trip = 1'b1;
				end else if (q.bcnt == 16'h0000) begin
					d.mode = ST_RUN; // RQ7
					d.acc  = '0;
				end else if (tenth) begin
					d.bcnt = q.bcnt - 16'h0001; // RQ6
				end
			end
			ST_RUN: begin
				if (instant_trip) begin
					do_trip   = 1'b1; // RQ10
					inst_trip = 1'b1;
				end else if (!over_w) begin
					d.acc = '0; // RQ15 RQ3
				end else if (tenth) begin
					if (heat_full) begin
						do_trip = 1'b1; // RQ9
					end else begin
						d.acc = heat_sum; // RQ9
					end
				end
			end
			ST_WAIT: begin
				// Restart once the delay has run out.
				if (q.wcnt == '0) begin
					d.mode    = ST_BYPASS; // RQ14
					d.bcnt    = q.cfg.bypass;
					d.left    = q.left - 8'h01; // RQ13
					d.run     = 1'b1;
					d.restart = 1'b1;
					ev_set[EV_RESTART] = 1'b1;
				end else if (tenth) begin
					d.wcnt = q.wcnt - WCNT_W'(1); // RQ14
				end
			end
			ST_LOCK: begin
				// Held until the operator clears it.
				if (clear_cmd) begin
					d.mode = ST_IDLE; // RQ16
					d.left = allowed; // RQ16
				end
			end
			default: begin
				d.mode = ST_IDLE;
			end
		endcase
		// Shutdown: lock out, or schedule a restart if any remain.
		if (do_trip) begin
			d.run = 1'b0;
			d.acc = '0;
			ev_set[EV_TRIP]    = !inst_trip;
			ev_set[EV_INSTANT] = inst_trip;
			if (q.cfg.lockout_en || (q.left == 8'h00)) begin
				d.mode = ST_LOCK; // RQ5 RQ13
				ev_set[EV_LOCK] = 1'b1;
			end else begin
				d.mode = ST_WAIT; // RQ12
				d.wcnt = WCNT_W'(delay_s * TENTHS_PER_SEC); // RQ14
			end
		end else if (stop_cmd && (q.mode != ST_LOCK)) begin
			// Operator stop returns to idle but never ends a lockout.
			d.mode = ST_IDLE;
			d.run  = 1'b0;
			d.acc  = '0;
		end
		// Sticky events: a new event wins over a clear.
		d.ev = (q.ev & ~ev_clr) | ev_set;
	end

	// State register.
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			q                   <= '0;
			q.mode              <= ST_IDLE;
			q.cfg.setpoint      <= SETPOINT_RST;
			q.cfg.bypass        <= BYPASS_RST;
			q.cfg.sdelay        <= SDELAY_RST;
			q.cfg.lstarts       <= LSTARTS_RST;
			q.cfg.ldelay        <= LDELAY_RST;
			q.cfg.gstarts       <= GSTARTS_RST;
			q.cfg.gdelay        <= GDELAY_RST;
		end else begin
			q <= d;
		end
	end

	// Outputs; the slave answers with no wait state.
	assign prdata        = q.prdata;
	assign pready        = 1'b1;
	assign pslverr       = psel && penable && !addr_ok(paddr);
	assign motor_run     = q.run;
	assign restart_pulse = q.restart;
	assign irq           = |(q.ev & q.mask);

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	// Highest reading follows the largest phase.
	property p_highest;
		1 |=> q.highest == $past(highest_w);
	endproperty
	a_highest: assert property (p_highest) // RQ1 RQ2
		else $error("highest current does not track largest phase");

	// A heat trip only with current above setpoint.
	property p_no_trip_below;
		(q.mode == ST_RUN && !over_w && !instant_trip) |=> q.run;
	endproperty
	a_no_trip_below: assert property (p_no_trip_below) // RQ3
		else $error("trip with current at or below setpoint");

	// Lockout enabled: a shutdown always locks.
	property p_lockout;
		(q.run && do_trip && q.cfg.lockout_en) |=> q.mode == ST_LOCK;
	endproperty
	a_lockout: assert property (p_lockout) // RQ5
		else $error("lockout not entered");

	// Overload ignored during bypass.
	property p_bypass;
		(q.mode == ST_BYPASS && !instant_trip && !stop_cmd)
			|=> q.mode inside {ST_BYPASS, ST_RUN};
	endproperty
	a_bypass: assert property (p_bypass) // RQ6
		else $error("overload acted during bypass");

	// Heat only accumulates in the run mode.
	property p_acc_run;
		(q.acc != '0) |-> q.mode == ST_RUN;
	endproperty
	a_acc_run: assert property (p_acc_run) // RQ7
		else $error("heat accumulated outside run");

	// Heat trip happens when the limit is reached.
	sequence s_heat_trip;
		q.mode == ST_RUN && !instant_trip && over_w && tenth;
	endsequence
	property p_heat;
		s_heat_trip ##0 heat_full |=> !q.run ##0 q.ev[EV_TRIP];
	endproperty
	a_heat: assert property (p_heat) // RQ8 RQ9
		else $error("heat limit reached without trip");

	// Drive self-trip stops the motor at once.
	property p_instant;
		(q.mode inside {ST_BYPASS, ST_RUN}) && instant_trip
			|=> !q.run && q.ev[EV_INSTANT];
	endproperty
	a_instant: assert property (p_instant) // RQ10
		else $error("instant trip not taken");

	// Restart option forces a single start.
	property p_one_start;
		q.cfg.rstrt_on_ovld |-> allowed == 8'h01 && use_local;
	endproperty
	a_one_start: assert property (p_one_start) // RQ11 RQ12
		else $error("restart option did not force one start");

	// A restart needs an expired delay in the wait mode.
	sequence s_waited;
		q.mode == ST_WAIT && q.wcnt == '0 && q.left != 8'h00;
	endsequence
	property p_restart;
		$rose(restart_pulse) |-> $past(q.mode == ST_WAIT && q.wcnt == '0);
	endproperty
	a_restart: assert property (p_restart) // RQ13 RQ14
		else $error("restart without expired delay");

	// Heat sum clears when current falls back.
	property p_acc_clear;
		(q.mode == ST_RUN && !over_w) |=> q.acc == '0;
	endproperty
	a_acc_clear: assert property (p_acc_clear) // RQ15
		else $error("heat sum not cleared");

	// Lockout holds until the clear command.
	property p_lock_hold;
		(q.mode == ST_LOCK && !clear_cmd) |=> q.mode == ST_LOCK;
	endproperty
	a_lock_hold: assert property (p_lock_hold) // RQ16 RQ5
		else $error("lockout left without clear");

	// Waiting with a start left leads to the restart.
	property p_wait_go;
		s_waited |=> restart_pulse && q.mode == ST_BYPASS;
	endproperty
	a_wait_go: assert property (p_wait_go) // RQ14
		else $error("restart not issued after delay");

endmodule : ovtr_top

/* File: sim/ovtr_stage.sv */
// Behavioural motor current sensor and power stage facing the block.
`timescale 1ns/1ps
module ovtr_stage
	import ovtr_pkg::*;
(
	// Clock.
	input  wire logic                   ref_clk,
	// Drive command and the load the bench wants the motor to draw.
	input  wire logic                   motor_run,
	input  wire ovtr_pkg::ovtr_phases_t demand,
	// Measured phase currents.
	output ovtr_pkg::ovtr_phases_t      phases
);
	import ovtr_pkg::*;

	// A stopped motor draws nothing; a running one draws the wanted load.
	always @(posedge ref_clk) begin
		phases <= (motor_run === 1'b1) ? demand : '0;
	end
endmodule : ovtr_stage

/* File: sim/testbench.sv */
// Self-checking bench of the overload trip and restart block.
`timescale 1ns/1ps
module testbench;
	import ovtr_pkg::*;
	localparam int TC = 10;            // Cycles per tenth in simulation.
	logic          ref_clk, rst, psel, penable, pwrite, instant_trip;
	logic [7:0]    paddr;
	logic [31:0]   pwdata, prdata, q;
	logic          pready, pslverr, motor_run, restart_pulse, irq, e;
	ovtr_phases_t  phases, demand;
	logic [15:0]   lfsr_q;              // Random source, fixed start.
	int            num_errors, comparisons, cyc, pulses, n, t0;
	int            sp, cur, sd, hot;
	// Control words, restart delay in cycles and allowed count per case.
	int            sd_tab[3] = '{4, 0, 2};
	int            dl_tab[3] = '{100, 200, 100};
	int            st_tab[3] = '{3, 2, 1};

	ovtr_top #(.TENTH_CYCLES_P(TC)) i_dut (.ref_clk(ref_clk), .rst(rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phases(phases), .instant_trip(instant_trip),
		.motor_run(motor_run), .restart_pulse(restart_pulse), .irq(irq));
	ovtr_stage i_stage (.ref_clk(ref_clk), .motor_run(motor_run),
		.demand(demand), .phases(phases));

	// Clock at 20 MHz.
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Free cycle count and count of automatic restarts seen.
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (restart_pulse === 1'b1) pulses <= pulses + 1;
	end

	// Next value of the random source.
	function automatic int rnd();
		lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
		return int'(lfsr_q);
	endfunction : rnd

	// Tenths of heating before a trip: ceil(45*sp^2*sd / (2*cur^2)).
	function automatic int exp_tenths(input int s, input int c, input int d);
		longint l, h;
		l = 45 * longint'(s) * s * d;
		h = 2 * longint'(c) * c;
		return int'((l + h - 1) / h);
	endfunction : exp_tenths

	// Prints the counts and the verdict, then stops the run.
	task automatic end_sim();
		$display("comparisons=%0d num_errors=%0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : end_sim

	// Compares a seen value with the expected one.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// One APB transfer; waits for pready under a bound.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic err);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge ref_clk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			num_errors++;
			end_sim();
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// One idle edge, so the next setup never meets this release.
		@(posedge ref_clk);
	endtask : apb

	// Register write and read.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, q, e);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0000_0000, q, e);
	endtask : rd

	// Waits for motor_run low (s=0) or a restart pulse (s=1); n is the wait.
	task automatic wait_sig(input int s, input int lim);
		for (n = 1; n <= lim; n++) begin
			@(posedge ref_clk);
			if (s == 0 && motor_run === 1'b0) break;
			if (s == 1 && restart_pulse === 1'b1) break;
		end
		if (n > lim) begin
			num_errors++;
			end_sim();
		end
	endtask : wait_sig

	// Resets the block and loads the short test timings.
	task automatic reset_dut();
		rst <= 1'b1;
		demand <= '0;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		wr(ADDR_BYPASS, 32'h2);
		wr(ADDR_LDELAY, 32'h1);
		wr(ADDR_GDELAY, 32'h2);
		wr(ADDR_LSTARTS, 32'h3);
		wr(ADDR_GSTARTS, 32'h2);
	endtask : reset_dut

	// Starts the motor against a load with one hot phase, cur on phase hot.
	task automatic run_load(input int c, input int h);
		logic [15:0] ph [3];
		ph = '{16'(c / 2), 16'(c / 3), 16'(c / 2)};
		ph[h] = 16'(c);
		demand <= {ph[0], ph[1], ph[2]};
		wr(ADDR_CMD, 32'h1 << CMD_START);
		t0 = cyc;
	endtask : run_load

	initial begin
		{rst, psel, penable, pwrite, instant_trip} = 5'h10;
		paddr = 8'h00;
		pwdata = 32'h0;
		demand = '0;
		lfsr_q = 16'd91;
		num_errors = 0;
		comparisons = 0;
		// Random overloads on a random phase, trip time from the heat curve.
		repeat (4) begin
			reset_dut();
			sp = 20 + rnd() % 60;
			cur = sp + 1 + rnd() % (2 * sp);
			sd = 1 + rnd() % 2;
			hot = rnd() % 3;
			wr(ADDR_SETPOINT, 32'(sp));
			wr(ADDR_SDELAY, 32'(sd));
			run_load(cur, hot);
			repeat (4) @(posedge ref_clk);
			rd(ADDR_HIGHEST);
			check(q, 32'(cur));
			wr(ADDR_HIGHEST, 32'h0);
			rd(ADDR_HIGHEST);
			check(q, 32'(cur));
			wait_sig(0, 20000);
			n = cyc - t0 - (2 + exp_tenths(sp, cur, sd)) * TC;
			check(32'(n >= -15 && n <= 25), 32'h1);
		end
		// Exactly at setpoint never trips; a dip clears the heat sum.
		reset_dut();
		wr(ADDR_SDELAY, 32'h1);
		run_load(50, 0);
		repeat (500) @(posedge ref_clk);
		check(32'(motor_run), 32'h1);
		demand <= {16'd75, 16'd0, 16'd0};
		repeat (60) @(posedge ref_clk);
		demand <= {16'd50, 16'd0, 16'd0};
		repeat (30) @(posedge ref_clk);
		demand <= {16'd75, 16'd0, 16'd0};
		t0 = cyc;
		wait_sig(0, 2000);
		check(32'(cyc - t0 >= 85), 32'h1);
		// Status keeps protection on; unmapped and unaligned are refused.
		wr(ADDR_STATUS, 32'h0);
		rd(ADDR_STATUS);
		check(q[16], 32'h1);
		rd(8'h3c);
		check(q, 32'h0);
		check(32'(e), 32'h1);
		rd(8'h01);
		check(e, 32'h1);
		// The power stage trips itself; event, mask and clear.
		reset_dut();
		wr(ADDR_INT_MASK, 32'h2);
		run_load(40, 1);
		repeat (40) @(posedge ref_clk);
		instant_trip <= 1'b1;
		wait_sig(0, 3);
		instant_trip <= 1'b0;
		rd(ADDR_INT_STAT);
		check(q[1] & irq, 32'h1);
		wr(ADDR_INT_MASK, 32'h0);
		@(posedge ref_clk);
		check(irq, 32'h0);
		wr(ADDR_INT_STAT, 32'hf);
		rd(ADDR_INT_STAT);
		check(q, 32'h0);
		// An operator stop while a restart is pending returns to idle.
		wr(ADDR_CMD, 32'h1 << CMD_STOP);
		rd(ADDR_STATUS);
		check(q[3:0], 32'h0);
		// Lockout enabled: no restart, then the operator clears it.
		reset_dut();
		wr(ADDR_CTRL, 32'h1 << CTRL_LOCKOUT);
		wr(ADDR_INT_MASK, 32'h4);
		run_load(100, 2);
		wait_sig(0, 2000);
		n = pulses;
		repeat (400) @(posedge ref_clk);
		rd(ADDR_STATUS);
		check(q[2:0], 32'h4);
		check(irq, 32'h1);
		check(32'(pulses - n), 32'h0);
		wr(ADDR_CMD, 32'h1 << CMD_CLEAR);
		rd(ADDR_STATUS);
		check(q[2:0], 32'h0);
		// Restart sets: local set, global set, option; delay and count.
		foreach (sd_tab[k]) begin
			reset_dut();
			wr(ADDR_CTRL, sd_tab[k]);
			run_load(100, k);
			wait_sig(0, 2000);
			wait_sig(1, 400);
			check(32'(n >= dl_tab[k] - 15 && n <= dl_tab[k] + 15), 32'h1);
			rd(ADDR_STATUS);
			check(q[15:8], 32'(st_tab[k] - 1));
		end
		wait_sig(0, 2000);
		repeat (5) @(posedge ref_clk);
		rd(ADDR_STATUS);
		check(q[2:0], 32'h4);
		wr(ADDR_CMD, 32'h1 << CMD_CLEAR);
		wr(ADDR_CMD, 32'h1 << CMD_START);
		rd(ADDR_STATUS);
		check(q[15:8], 32'h1);
		end_sim();
	end

endmodule : testbench
